// [dpf_fifo_status_control.sv]
// datapath fifo pair: direction, load modes, software capture, flush and status
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps

module dpf_fifo_status_control import dpf_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input dpf_bus_type bus_req,
    output logic [DW-1:0] rdata,
    input wire logic dp_tick,
    input wire logic [NF-1:0] fifo_load_strobe,
    input wire logic [NF-1:0] dp_consume,
    input wire logic [DW-1:0] accumulator_zero,
    input wire logic [DW-1:0] accumulator_one,
    input wire logic [DW-1:0] alu_result,
    input wire logic [NF-1:0] chain_in,
    output logic [NF-1:0] chain_out,
    output logic [NF-1:0] bus_stat,
    output logic [NF-1:0] blk_stat,
    output logic [NF-1:0][DW-1:0] dp_fifo_data
);
    dpf_top_type state_r;
    dpf_top_type state_nxt;

    dpf_dir_type dir [NF];
    logic [DW-1:0] src [NF];
    logic [DW-1:0] wd [NF];
    logic [DW-1:0] front [NF];
    logic [CW-1:0] cnt [NF];
    logic [CW-1:0] need [NF];
    logic [NF-1:0] is_out;
    logic [NF-1:0] flush;
    logic [NF-1:0] lvl;
    logic [NF-1:0] hw_ld;
    logic [NF-1:0] cap_wr;
    logic [NF-1:0] acc_rd;
    logic [NF-1:0] f_wr;
    logic [NF-1:0] f_rd;
    logic [NF-1:0] raw_bus;
    logic [NF-1:0] raw_blk;
    logic samp;

    // fast mode samples the load strobe every bus clock
    assign samp = state_r.cfg.fast | dp_tick;

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_fifo
            localparam logic [AW-1:0] FA = (g == 0) ? ADDR_FIFO0 : ADDR_FIFO1;
            localparam logic [AW-1:0] AA = (g == 0) ? ADDR_ACC0 : ADDR_ACC1;

            assign dir[g] = (g == 0) ? state_r.cfg.dir0 : state_r.cfg.dir1;
            assign flush[g] = (g == 0) ? state_r.aux.flush0 : state_r.aux.flush1;
            assign lvl[g] = (g == 0) ? state_r.aux.lvl0 : state_r.aux.lvl1;
            assign is_out[g] = (dir[g] != DIR_BUS_IN);

            // output-mode source selection
            assign src[g] = (dir[g] == DIR_ACC0) ? accumulator_zero :
                (dir[g] == DIR_ACC1) ? accumulator_one : alu_result;
            assign wd[g] = is_out[g] ? src[g] : bus_req.wdata;

            // level mode loads while high, edge mode only on a fresh rise
            assign hw_ld[g] = samp & fifo_load_strobe[g]
                & (~state_r.cfg.edge_mode | ~state_r.ld_prev[g]);
            // the read is registered, so local and chained triggers line up
            assign acc_rd[g] = bus_req.rd && (bus_req.addr == AA);
            assign cap_wr[g] = state_r.cfg.swcap_en & (state_r.cap[g] | chain_in[g]);

            // hardware load and software capture simply OR together
            assign f_wr[g] = is_out[g] ? (hw_ld[g] | cap_wr[g])
                : (bus_req.wr && (bus_req.addr == FA));
            assign f_rd[g] = is_out[g] ? (bus_req.rd && (bus_req.addr == FA))
                : dp_consume[g];

            // status thresholds from the occupancy count
            assign need[g] = lvl[g] ? LVL_TWO : LVL_ONE;
            assign raw_bus[g] = !flush[g] && (is_out[g] ? (cnt[g] >= need[g])
                : (cnt[g] <= (CNT_FULL - need[g])));
            assign raw_blk[g] = !flush[g] && (is_out[g] ? (cnt[g] == CNT_FULL)
                : (cnt[g] == CNT_EMPTY));

            dpf_fifo_core u_core (
                .clk(clk),
                .nrst(nrst),
                .flush(flush[g]),
                .wr(f_wr[g]),
                .wdata(wd[g]),
                .rd(f_rd[g]),
                .front(front[g]),
                .cnt(cnt[g])
            );
        end
    endgenerate

    // register port: one-cycle strobes, the slave never stalls the master
    logic cfg_wr;
    logic aux_wr;
    logic rd_cfg;
    logic rd_aux;
    logic rd_f0;
    logic rd_f1;
    logic rd_stat;
    logic rd_level;
    logic [DW-1:0] stat_word;
    logic [DW-1:0] level_word;
    logic [DW-1:0] rd_word;

    // address decode for writes
    assign cfg_wr = bus_req.wr && (bus_req.addr == ADDR_CFG);
    assign aux_wr = bus_req.wr && (bus_req.addr == ADDR_AUX);

    // address decode for reads
    assign rd_cfg = bus_req.rd && (bus_req.addr == ADDR_CFG);
    assign rd_aux = bus_req.rd && (bus_req.addr == ADDR_AUX);
    assign rd_f0 = bus_req.rd && (bus_req.addr == ADDR_FIFO0);
    assign rd_f1 = bus_req.rd && (bus_req.addr == ADDR_FIFO1);
    assign rd_stat = bus_req.rd && (bus_req.addr == ADDR_STAT);
    assign rd_level = bus_req.rd && (bus_req.addr == ADDR_LEVEL);

    // status and occupancy words, padded up to the bus width on purpose
    assign stat_word = DW'({state_r.blk_stat, state_r.bus_stat});
    assign level_word = DW'({cnt[1], cnt[0]});

    // read mux; the fifo head is taken before the pop lands on the same edge
    // an accumulator read returns the live value, which capture users discard
    assign rd_word = rd_f0 ? front[0] :
        rd_f1 ? front[1] :
        acc_rd[0] ? accumulator_zero :
        acc_rd[1] ? accumulator_one :
        rd_cfg ? DW'(state_r.cfg) :
        rd_aux ? DW'(state_r.aux) :
        rd_stat ? stat_word :
        rd_level ? level_word :
        '0;

    // next state: register file, per-fifo status and load tracking
    always_comb begin
        state_nxt = state_r;
        // read data stand for one cycle only, zero otherwise
        state_nxt.rdata = rd_word;
        if (cfg_wr) begin
            state_nxt.cfg = dpf_cfg_type'(bus_req.wdata);
        end
        // flush bits stay as written until software clears them
        if (aux_wr) begin
            state_nxt.aux = dpf_aux_type'(bus_req.wdata[AUX_W-1:0]);
        end
        for (int i = 0; i < NF; i++) begin
            // one edge bit for both, tracked at the sampling rate
            if (samp) begin
                state_nxt.ld_prev[i] = fifo_load_strobe[i];
            end
            state_nxt.cap[i] = acc_rd[i];
            state_nxt.bus_stat[i] = raw_bus[i];
            // second flop of the resync chain reads only the first
            state_nxt.sync1[i] = raw_blk[i];
            state_nxt.sync2[i] = state_r.sync1[i];
            if (state_r.cfg.async_en) begin
                // bus side clears show up here two clocks later
                state_nxt.blk_stat[i] = state_r.sync2[i];
            end else if (dp_tick) begin
                state_nxt.blk_stat[i] = raw_blk[i];
            end
            // head byte registered for the datapath sinks
            state_nxt.dp_data[i] = front[i];
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= TOP_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // every output comes straight from the state register
    assign rdata = state_r.rdata;
    assign chain_out = state_r.cap;
    assign bus_stat = state_r.bus_stat;
    assign blk_stat = state_r.blk_stat;
    assign dp_fifo_data = state_r.dp_data;

    // a flush empties fifo zero on the edge it is seen
    // so the next edge finds a zero count
    AST_FLUSH_EMPTY0: assert property (@(posedge clk) disable iff (!nrst)
        flush[0]
        |=> (cnt[0] == CNT_EMPTY))
        else $error("fifo zero count not cleared by flush");

    // same for fifo one
    // pointers restart from a known place
    AST_FLUSH_EMPTY1: assert property (@(posedge clk) disable iff (!nrst)
        flush[1]
        |=> (cnt[1] == CNT_EMPTY))
        else $error("fifo one count not cleared by flush");

    // a held flush turns fifo zero into a buffer
    // that raises no bus status at all
    AST_FLUSH_QUIET0: assert property (@(posedge clk) disable iff (!nrst)
        flush[0]
        |=> !bus_stat[0])
        else $error("fifo zero shows status while flushed");

    // same for fifo one
    // the service request must stay quiet
    AST_FLUSH_QUIET1: assert property (@(posedge clk) disable iff (!nrst)
        flush[1]
        |=> !bus_stat[1])
        else $error("fifo one shows status while flushed");

    // output fifo zero full on a datapath tick
    // must report full to the datapath next
    AST_FULL_BLK0: assert property (@(posedge clk) disable iff (!nrst)
        (is_out[0] && !flush[0] && !state_r.cfg.async_en && dp_tick && (cnt[0] == CNT_FULL))
        |=> blk_stat[0])
        else $error("fifo zero full not flagged");

    // output fifo one full on a datapath tick
    // must report full to the datapath next
    AST_FULL_BLK1: assert property (@(posedge clk) disable iff (!nrst)
        (is_out[1] && !flush[1] && !state_r.cfg.async_en && dp_tick && (cnt[1] == CNT_FULL))
        |=> blk_stat[1])
        else $error("fifo one full not flagged");

    // input fifo zero with nothing stored
    // must report empty so the datapath idles
    AST_EMPTY_BLK0: assert property (@(posedge clk) disable iff (!nrst)
        (!is_out[0] && !flush[0] && !state_r.cfg.async_en && dp_tick && (cnt[0] == CNT_EMPTY))
        |=> blk_stat[0])
        else $error("fifo zero empty not flagged");

    // input fifo one with nothing stored
    // must report empty so the datapath idles
    AST_EMPTY_BLK1: assert property (@(posedge clk) disable iff (!nrst)
        (!is_out[1] && !flush[1] && !state_r.cfg.async_en && dp_tick && (cnt[1] == CNT_EMPTY))
        |=> blk_stat[1])
        else $error("fifo one empty not flagged");

    // an empty input fifo at the low level
    // always has room, so bus status is up
    AST_BUS_IN_LVL0: assert property (@(posedge clk) disable iff (!nrst)
        (!is_out[0] && !flush[0] && !lvl[0] && (cnt[0] == CNT_EMPTY))
        |=> bus_stat[0])
        else $error("fifo zero room not signalled");

    // a full input fifo has no room
    // whatever the level select says
    AST_BUS_IN_LVL1: assert property (@(posedge clk) disable iff (!nrst)
        (!is_out[1] && !flush[1] && (cnt[1] == CNT_FULL))
        |=> !bus_stat[1])
        else $error("fifo one room signalled while full");

    // one byte is not enough for the high level
    // of an output fifo
    AST_BUS_OUT_LVL0: assert property (@(posedge clk) disable iff (!nrst)
        (is_out[0] && !flush[0] && lvl[0] && (cnt[0] == CNT_ONE))
        |=> !bus_stat[0])
        else $error("fifo zero high level raised too early");

    // any stored byte raises the low level
    // of an output fifo
    AST_BUS_OUT_LVL1: assert property (@(posedge clk) disable iff (!nrst)
        (is_out[1] && !flush[1] && !lvl[1] && (cnt[1] != CNT_EMPTY))
        |=> bus_stat[1])
        else $error("fifo one readable byte not signalled");

    // occupancy never passes the depth
    // even under overflow
    AST_CNT_BOUND0: assert property (@(posedge clk) disable iff (!nrst)
        1'b1
        |-> (cnt[0] <= CNT_FULL))
        else $error("fifo zero count out of range");

    // occupancy never passes the depth
    // even under overflow
    AST_CNT_BOUND1: assert property (@(posedge clk) disable iff (!nrst)
        1'b1
        |-> (cnt[1] <= CNT_FULL))
        else $error("fifo one count out of range");

    // an accumulator zero read is passed down the chain
    // on the next edge, in step with the local capture
    AST_CHAIN0: assert property (@(posedge clk) disable iff (!nrst)
        acc_rd[0]
        |=> chain_out[0])
        else $error("chain trigger zero missing");

    // an accumulator one read is passed down the chain
    // on the next edge, in step with the local capture
    AST_CHAIN1: assert property (@(posedge clk) disable iff (!nrst)
        acc_rd[1]
        |=> chain_out[1])
        else $error("chain trigger one missing");

    // a write into a full fifo zero with no read
    // leaves the count at full
    AST_OVERWRITE0: assert property (@(posedge clk) disable iff (!nrst)
        (f_wr[0] && !f_rd[0] && !flush[0] && (cnt[0] == CNT_FULL))
        |=> (cnt[0] == CNT_FULL))
        else $error("fifo zero count moved on overflow");

    // a write into a full fifo one with no read
    // leaves the count at full
    AST_OVERWRITE1: assert property (@(posedge clk) disable iff (!nrst)
        (f_wr[1] && !f_rd[1] && !flush[1] && (cnt[1] == CNT_FULL))
        |=> (cnt[1] == CNT_FULL))
        else $error("fifo one count moved on overflow");

    // the overflowing byte lands at the head
    // so it is the next one read
    AST_OVERWRITE_HEAD1: assert property (@(posedge clk) disable iff (!nrst)
        (f_wr[1] && !f_rd[1] && !flush[1] && (cnt[1] == CNT_FULL))
        |=> (front[1] == $past(wd[1])))
        else $error("fifo one head not overwritten");

    // async mode feeds block status from the second sync flop
    // which costs two extra clocks of lag
    AST_ASYNC_PATH: assert property (@(posedge clk) disable iff (!nrst)
        state_r.cfg.async_en
        |=> (blk_stat == $past(state_r.sync2)))
        else $error("block status bypassed the resync chain");

    // without async mode block status follows the count directly
    // and bus status never takes the sync path
    AST_SYNC_PATH: assert property (@(posedge clk) disable iff (!nrst)
        (!state_r.cfg.async_en && dp_tick)
        |=> (blk_stat == $past(raw_blk)))
        else $error("block status lagged in sync mode");

    // overflow on fifo one
    COV_OVERWRITE: cover property (@(posedge clk) disable iff (!nrst)
        f_wr[1] && !flush[1] && (cnt[1] == CNT_FULL));

    // software capture into fifo zero
    COV_SWCAP: cover property (@(posedge clk) disable iff (!nrst)
        cap_wr[0] && is_out[0]);

    // edge-mode hardware load
    COV_EDGE_LOAD: cover property (@(posedge clk) disable iff (!nrst)
        state_r.cfg.edge_mode && hw_ld[1]);

    // datapath consuming from the input fifo
    COV_CONSUME: cover property (@(posedge clk) disable iff (!nrst)
        !is_out[0] && dp_consume[0] && (cnt[0] != CNT_EMPTY));
endmodule

// [dpf_fifo_core.sv]
// package for the datapath fifo status/control block and the 4-byte fifo storage core
//
// Overview of operation
// - direction 00 bus-in; 01/10/11 acc0/acc1/alu out
// - input bus status: room for 1, or 2
// - input block status flags empty for datapath
// - output bus status: 1 readable, or 2
// - output block status flags full for datapath
// - bus status routed out as service request
// - same-cycle read and write both take effect, except a read from empty
// - load sampled on datapath tick, or fast
// - level mode writes every sampled high cycle
// - edge mode captures on rising load edge
// - one edge bit, detected at sampling rate
// - accumulator read captures into output fifo
// - capture trigger chains to linked blocks
// - load strobe ORed with software capture
// - flush bit resets fifo until cleared
// - flushed fifo is one-byte buffer, no status
// - async mode resynchronises block status
// - one async bit, block status only
// - write when full overwrites front entry
// - underflow data undefined, pointers stay right
package dpf_pkg;
    localparam int DW = 8;
    localparam int DEPTH = 4;
    localparam int PW = 2;
    localparam int CW = 3;
    localparam int AW = 8;
    localparam int NF = 2;

    // register map
    localparam logic [AW-1:0] ADDR_CFG = 8'h00;
    localparam logic [AW-1:0] ADDR_AUX = 8'h04;
    localparam logic [AW-1:0] ADDR_FIFO0 = 8'h08;
    localparam logic [AW-1:0] ADDR_FIFO1 = 8'h0c;
    localparam logic [AW-1:0] ADDR_ACC0 = 8'h10;
    localparam logic [AW-1:0] ADDR_ACC1 = 8'h14;
    localparam logic [AW-1:0] ADDR_STAT = 8'h18;
    localparam logic [AW-1:0] ADDR_LEVEL = 8'h1c;

    // occupancy figures
    localparam logic [CW-1:0] CNT_EMPTY = 3'h0;
    localparam logic [CW-1:0] CNT_ONE = 3'h1;
    localparam logic [CW-1:0] CNT_FULL = 3'h4;
    localparam logic [CW-1:0] LVL_ONE = 3'h1;
    localparam logic [CW-1:0] LVL_TWO = 3'h2;
    localparam logic [PW-1:0] PTR_ZERO = 2'h0;
    localparam logic [PW-1:0] PTR_ONE = 2'h1;

    typedef enum logic [1:0] {
        DIR_BUS_IN = 2'b00,
        DIR_ACC0 = 2'b01,
        DIR_ACC1 = 2'b10,
        DIR_ALU = 2'b11
    } dpf_dir_type;

    typedef struct packed {
        logic async_en;
        logic swcap_en;
        logic fast;
        logic edge_mode;
        dpf_dir_type dir1;
        dpf_dir_type dir0;
    } dpf_cfg_type;

    typedef struct packed {
        logic lvl1;
        logic lvl0;
        logic flush1;
        logic flush0;
    } dpf_aux_type;

    localparam int AUX_W = $bits(dpf_aux_type);

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } dpf_bus_type;

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] cnt;
    } dpf_core_type;

    typedef struct packed {
        dpf_cfg_type cfg;
        dpf_aux_type aux;
        logic [DW-1:0] rdata;
        logic [NF-1:0] bus_stat;
        logic [NF-1:0] blk_stat;
        logic [NF-1:0] ld_prev;
        logic [NF-1:0] cap;
        logic [NF-1:0] sync1;
        logic [NF-1:0] sync2;
        logic [NF-1:0][DW-1:0] dp_data;
    } dpf_top_type;

    localparam dpf_core_type CORE_RST = '0;
    localparam dpf_top_type TOP_RST = '0;
endpackage

`timescale 1ns/1ps

module dpf_fifo_core import dpf_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic wr,
    input wire logic [DW-1:0] wdata,
    input wire logic rd,
    output logic [DW-1:0] front,
    output logic [CW-1:0] cnt
);
    dpf_core_type state_r;
    dpf_core_type state_nxt;
    logic do_rd;
    logic wr_ok;

    // flushed core serves slot zero as a plain one-byte buffer
    assign front = flush ? state_r.mem[PTR_ZERO] : state_r.mem[state_r.rptr];
    assign cnt = state_r.cnt;
    // a pop from empty is dropped so the pointers stay true
    assign do_rd = rd && (state_r.cnt != CNT_EMPTY);
    assign wr_ok = wr && !((state_r.cnt == CNT_FULL) && !do_rd);

    // pointer and count update; read and write may share a cycle
    always_comb begin
        state_nxt = state_r;
        if (flush) begin
            state_nxt.wptr = PTR_ZERO;
            state_nxt.rptr = PTR_ZERO;
            state_nxt.cnt = CNT_EMPTY;
            if (wr) begin
                state_nxt.mem[PTR_ZERO] = wdata;
            end
        end else begin
            if (wr_ok) begin
                state_nxt.mem[state_r.wptr] = wdata;
                state_nxt.wptr = state_r.wptr + PTR_ONE;
            end else if (wr) begin
                // no overflow guard: newest byte replaces the head
                state_nxt.mem[state_r.rptr] = wdata;
            end
            if (do_rd) begin
                state_nxt.rptr = state_r.rptr + PTR_ONE;
            end
            state_nxt.cnt = state_r.cnt + (wr_ok ? CNT_ONE : CNT_EMPTY)
                - (do_rd ? CNT_ONE : CNT_EMPTY);
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= CORE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule

// [dpf_bus_master.sv]
// bus master model standing in for the cpu or dma on the register port
`timescale 1ns/1ps

module dpf_bus_master import dpf_pkg::*; (
    input wire logic clk,
    input wire logic [DW-1:0] rdata,
    output dpf_bus_type bus_req
);
    // idle port until the first request
    initial begin
        bus_req = '0;
    end

    // one write strobe cycle; released lines show inverted values, never the last ones
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // read data stand only in the cycle after the strobe, so sample inside it
    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(posedge clk);
        d = rdata;
    endtask
endmodule

// [dpf_fifo_status_control_tb_top.sv]
// self-checking bench for the datapath fifo pair
`timescale 1ns/1ps

module dpf_fifo_status_control_tb_top import dpf_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    dpf_bus_type bus_req;
    logic [DW-1:0] rdata, acc0 = 8'h00, acc1 = 8'h00, alu = 8'h00, d;
    logic [NF-1:0] ld = '0, chain_out, bus_stat, blk_stat;
    logic [NF-1:0][DW-1:0] dp_fifo_data;
    logic [15:0] lfsr = 16'h6478;
    logic tick = 1'b1, saw_chain = 1'b0;
    logic [NF-1:0] cons = '0, chn = '0;
    logic [DW-1:0] q[$];
    int err_count = 0, tests_run = 0, cyc = 0;

    dpf_fifo_status_control dpf_fifo_status_control_inst (.clk(clk), .nrst(nrst), .bus_req(bus_req),
        .rdata(rdata), .dp_tick(tick), .fifo_load_strobe(ld), .dp_consume(cons), .accumulator_zero(acc0),
        .accumulator_one(acc1), .alu_result(alu), .chain_in(chn), .chain_out(chain_out),
        .bus_stat(bus_stat), .blk_stat(blk_stat), .dp_fifo_data(dp_fifo_data));
    dpf_bus_master dpf_bus_master_inst (.clk(clk), .rdata(rdata), .bus_req(bus_req));

    // 250 mhz clock
    always #2 clk = ~clk;

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // latch a chained trigger the block passes on at chain_out[0]
    always @(posedge clk) begin
        if (chain_out[0]) saw_chain <= 1'b1;
    end

    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // flush both fifos, then release so normal operation resumes
    task automatic flush_all();
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h03);
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h00);
        repeat (3) @(posedge clk);
    endtask

    // drive random accumulator one with the load held for n cycles; keeps expected bytes
    task automatic load1(input int n);
        repeat (n) begin
            @(posedge clk);
            lfsr = nx(lfsr);
            acc1 <= lfsr[7:0];
            alu <= lfsr[15:8];
            ld <= 2'b10;
            q.push_back(lfsr[7:0]);
        end
        @(posedge clk);
        ld <= 2'b00;
        repeat (3) @(posedge clk);
    endtask

    // one datapath consume pulse on fifo zero, then let the resync settle
    task automatic consume0();
        @(posedge clk);
        cons <= 2'b01;
        @(posedge clk);
        cons <= 2'b00;
        repeat (4) @(posedge clk);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'h28);
        flush_all();
        chk({blk_stat[0], bus_stat[0]}, 8'h03);
        for (int i = 0; i < 3; i++) dpf_bus_master_inst.wr_reg(ADDR_FIFO0, 8'h5a);
        repeat (3) @(posedge clk);
        chk({blk_stat[0], bus_stat[0]}, 8'h01);
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h04);
        repeat (3) @(posedge clk);
        chk(bus_stat[0], 8'h00);
        // level loads into output fifo one, five writes overflow it
        load1(5);
        chk(blk_stat[1], 8'h01);
        dpf_bus_master_inst.rd_reg(ADDR_FIFO1, d);
        chk(d, q[4]);
        for (int i = 1; i < 4; i++) begin
            dpf_bus_master_inst.rd_reg(ADDR_FIFO1, d);
            chk(d, q[i]);
        end
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h00);
        repeat (3) @(posedge clk);
        chk(bus_stat[1], 8'h00);
        // edge mode: a load held three cycles writes once
        q.delete();
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'h38);
        flush_all();
        load1(3);
        chk(bus_stat[1], 8'h01);
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h08);
        repeat (3) @(posedge clk);
        chk(bus_stat[1], 8'h00);
        dpf_bus_master_inst.rd_reg(ADDR_FIFO1, d);
        chk(d, q[0]);
        // software capture of accumulator zero; the accumulator read value is discarded
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'h69);
        flush_all();
        lfsr = nx(lfsr);
        acc0 <= lfsr[7:0];
        dpf_bus_master_inst.rd_reg(ADDR_ACC0, d);
        dpf_bus_master_inst.rd_reg(ADDR_FIFO0, d);
        chk(d, acc0);
        // a chained trigger captures accumulator one into output fifo one
        lfsr = nx(lfsr);
        acc1 <= lfsr[7:0];
        @(posedge clk);
        chn <= 2'b10;
        @(posedge clk);
        chn <= 2'b00;
        dpf_bus_master_inst.rd_reg(ADDR_FIFO1, d);
        chk(d, acc1);
        chk(saw_chain, 8'h01);
        // async status: the datapath drains input fifo zero
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'ha8);
        flush_all();
        dpf_bus_master_inst.wr_reg(ADDR_FIFO0, 8'h11);
        dpf_bus_master_inst.wr_reg(ADDR_FIFO0, 8'h22);
        repeat (4) @(posedge clk);
        chk(blk_stat[0], 8'h00);
        chk(dp_fifo_data[0], 8'h11);
        consume0();
        chk(dp_fifo_data[0], 8'h22);
        consume0();
        chk(blk_stat[0], 8'h01);
        // normal sampling: with no datapath tick the load is not taken
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'h08);
        flush_all();
        tick <= 1'b0;
        load1(2);
        chk(bus_stat[1], 8'h00);
        tick <= 1'b1;
        load1(1);
        chk(bus_stat[1], 8'h01);
        q.delete();
        // flush held: input fifo zero acts as a one-byte buffer
        dpf_bus_master_inst.wr_reg(ADDR_CFG, 8'h28);
        dpf_bus_master_inst.wr_reg(ADDR_AUX, 8'h01);
        dpf_bus_master_inst.wr_reg(ADDR_FIFO0, 8'h3c);
        dpf_bus_master_inst.wr_reg(ADDR_FIFO0, 8'hc3);
        repeat (3) @(posedge clk);
        chk(dp_fifo_data[0], 8'hc3);
        tally_and_finish();
    end
endmodule
